// >>> verilog/asr_defines.svh
// Offsets, field positions, reset values and timing counts of the sensor control registers.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// Register indexes; the byte address on the bus is four times the index.
`define ASR_IDX_SYNC      6'h2b
`define ASR_IDX_RANGE     6'h2c
`define ASR_IDX_POWER     6'h2d
`define ASR_IDX_SELF      6'h2e
`define ASR_IDX_IRQ_STAT  6'h30
`define ASR_IDX_IRQ_MASK  6'h31
`define ASR_IDX_STATE     6'h32

// Reset values.
`define ASR_RST_SYNC      8'h00
`define ASR_RST_RANGE     8'h81
`define ASR_RST_POWER     8'h01
`define ASR_RST_SELF      8'h00

// Writable bits of each register; reserved bits are never stored.
`define ASR_WMASK_SYNC    8'h07
`define ASR_WMASK_RANGE   8'hc3
`define ASR_WMASK_POWER   8'h07
`define ASR_WMASK_SELF    8'h03
`define ASR_WMASK_IRQ     8'h03

// Field positions.
`define ASR_SYNC_MODE_HI  1
`define ASR_SYNC_CLK_BIT  2
`define ASR_RNG_HS_BIT    7
`define ASR_RNG_POL_BIT   6
`define ASR_RNG_FS_HI     1
`define ASR_PWR_MASK_BIT  2
`define ASR_PWR_TOFF_BIT  1
`define ASR_PWR_STBY_BIT  0
`define ASR_ST_MODE_BIT   0
`define ASR_ST_FORCE_BIT  1
`define ASR_IRQ_READY_BIT 0
`define ASR_IRQ_OVR_BIT   1

// Interpolation delay in oscillator cycles and the top rate/filter code.
`define ASR_INTERP_MIN    13'd8
`define ASR_INTERP_MAX    4102
`define ASR_RATE_TOP      4'ha

// Bus answers.
`define ASR_RESP_OKAY     2'b00
`define ASR_RESP_SLVERR   2'b10

`endif

// >>> verilog/asr_pkg.sv
// Types shared by the sensor control register block.
`default_nettype none
package asr_pkg;

    // Sample synchronisation modes.
    typedef enum logic [1:0] {
        ASR_SYNC_INTERNAL   = 2'b00,
        ASR_SYNC_EXT_DIRECT = 2'b01,
        ASR_SYNC_EXT_INTERP = 2'b10,
        ASR_SYNC_RESERVED   = 2'b11
    } asr_sync_e;

    typedef logic [12:0] asr_dly_t;

endpackage : asr_pkg
`default_nettype wire

// >>> verilog/asr_dly_counter.sv
// Down counter that times the interpolation delay from trigger to sample ready.
`timescale 1ns/1ps
`default_nettype none
module asr_dly_counter
    import asr_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire logic     start,
    input  wire logic     abort,
    input  wire asr_dly_t load,
    output logic          busy,
    output logic          done
);

    asr_dly_t cnt_q;
    logic     busy_q;

    // Loads load-2 so that done rises load-1 cycles after start.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 13'h0000;
            busy_q <= 1'b0;
        end else if (abort) begin
            busy_q <= 1'b0;
        end else if (start && !busy_q) begin
            cnt_q  <= load - 13'h0002;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (cnt_q == 13'h0000) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 13'h0001;
            end
        end
    end

    // The terminal count marks the cycle before the ready pulse.
    assign busy = busy_q;
    assign done = busy_q && (cnt_q == 13'h0000) && !abort;

endmodule : asr_dly_counter
`default_nettype wire

// >>> verilog/asr_regs.sv
// Sampling, range, power and self-check control registers behind an AXI4-Lite slave.
//
// Contract
// - Sync field 00 selects internal sample timing; code 11 is reserved.
// - Sync 01: after synchronising, sample ready pulses on each external trigger.
// - Sync 10: ready comes 8 to 4102 cycles after trigger, longer for higher rate.
// - Interpolated samples represent acceleration one group delay before the trigger.
// - Sync bit 2 selects the outside sampling clock.
// - Range bit 7 selects high-speed bus mode; register resets to 0x81.
// - Range bit 6 sets both interrupt outputs active high, else active low.
// - Range bits 1:0 select 10, 20 or 40 g full scale; reset 01.
// - Power bit 2 forces the sample ready output to 0.
// - Power bit 1 stops temperature processing.
// - Standby also stops temperature processing; power resets to 0x01, standby.
// - Sync register resets to 0x00; bits 7 to 3 reserved, read-only.
// - Self-check register resets to 0x00; bits 7 to 2 reserved, read-only.
// - Self-check bit 0 enables self-check mode.
// - Self-check bit 1 applies the self-check force.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "asr_defines.svh"
module asr_regs
    import asr_pkg::*;
#(
    parameter int unsigned INTERP_MAX_CYC = `ASR_INTERP_MAX
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic        SAMPLE_TICK,
    input  wire logic        SYNC_TRIG,
    input  wire logic [3:0]  RATE_FILTER_SETTING,
    output logic             SAMPLE_READY_PIN,
    output logic             OUTSIDE_CLOCK_SELECT,
    output logic             BUS_HIGH_SPEED_SEL,
    output logic [1:0]       RANGE_SEL,
    output logic             TEMP_PROC_EN,
    output logic             STANDBY,
    output logic             SELFCHECK_MODE_EN,
    output logic             SELFCHECK_FORCE_EN,
    output logic             IRQ,
    output logic             IRQ_OUT_A,
    output logic             IRQ_OUT_B
);

    localparam asr_dly_t MAX_DLY = asr_dly_t'(INTERP_MAX_CYC);

    logic [7:0]  sync_q, range_q, power_q, self_q, irq_stat_q, irq_mask_q;
    logic        aw_rdy_q, w_rdy_q, ar_rdy_q, bvalid_q, rvalid_q;
    logic [7:0]  aw_addr_q, w_lo_q;
    logic        w_s0_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q, rd_data;
    logic        rd_ok, wr_ok, wr_fire;
    logic        trig_q, trig_rise, synced_q, ready_q, temp_en_q;
    logic        irq_q, irq_a_q, irq_b_q;
    logic        active, rdy_src, dly_start, dly_abort, dly_busy, dly_done;
    logic [7:0]  irq_set, irq_clr;
    asr_dly_t    dly_load, dly_shift;
    asr_sync_e   sync_mode;

    // Write channel: address and data are taken independently, the write fires when both are held.
    assign wr_fire = !aw_rdy_q && !w_rdy_q && !bvalid_q;
    assign wr_ok   = aw_addr_q[1:0] == 2'b00 && aw_addr_q[7:2] >= `ASR_IDX_SYNC
                     && aw_addr_q[7:2] <= `ASR_IDX_STATE && aw_addr_q[7:2] != 6'h2f;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_rdy_q  <= 1'b1;
            w_rdy_q   <= 1'b1;
            aw_addr_q <= 8'h00;
            w_lo_q    <= 8'h00;
            w_s0_q    <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `ASR_RESP_OKAY;
        end else begin
            if (AWVALID && aw_rdy_q) begin
                aw_addr_q <= AWADDR;
                aw_rdy_q  <= 1'b0;
            end
            if (WVALID && w_rdy_q) begin
                w_lo_q  <= WDATA[7:0];
                w_s0_q  <= WSTRB[0];
                w_rdy_q <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
                aw_rdy_q <= 1'b1;
                w_rdy_q  <= 1'b1;
            end else if (bvalid_q && BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Configuration registers; only aligned, mapped writes land, and reserved bits are masked off.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync_q     <= `ASR_RST_SYNC;
            range_q    <= `ASR_RST_RANGE;
            power_q    <= `ASR_RST_POWER;
            self_q     <= `ASR_RST_SELF;
            irq_mask_q <= 8'h00;
        end else if (wr_fire && w_s0_q && wr_ok) begin
            case (aw_addr_q[7:2])
                `ASR_IDX_SYNC:     sync_q     <= w_lo_q & `ASR_WMASK_SYNC;
                `ASR_IDX_RANGE:    range_q    <= w_lo_q & `ASR_WMASK_RANGE;
                `ASR_IDX_POWER:    power_q    <= w_lo_q & `ASR_WMASK_POWER;
                `ASR_IDX_SELF:     self_q     <= w_lo_q & `ASR_WMASK_SELF;
                `ASR_IDX_IRQ_MASK: irq_mask_q <= w_lo_q & `ASR_WMASK_IRQ;
                default: ;
            endcase
        end
    end

    // Read channel: one read at a time, answered the cycle after the address is taken.
    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        if (ARADDR[1:0] != 2'b00) begin
            rd_ok = 1'b0;
        end else begin
            case (ARADDR[7:2])
                `ASR_IDX_SYNC:     rd_data = {24'h00_0000, sync_q};
                `ASR_IDX_RANGE:    rd_data = {24'h00_0000, range_q};
                `ASR_IDX_POWER:    rd_data = {24'h00_0000, power_q};
                `ASR_IDX_SELF:     rd_data = {24'h00_0000, self_q};
                `ASR_IDX_IRQ_STAT: rd_data = {24'h00_0000, irq_stat_q};
                `ASR_IDX_IRQ_MASK: rd_data = {24'h00_0000, irq_mask_q};
                `ASR_IDX_STATE:    rd_data = {29'h0000_0000, temp_en_q, dly_busy, synced_q};
                default:           rd_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `ASR_RESP_OKAY;
        end else if (ARVALID && ar_rdy_q) begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q  <= rd_data;
            rresp_q  <= rd_ok ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
        end else if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
            ar_rdy_q <= 1'b1;
        end
    end

    // Mode decode and the trigger edge.
    assign sync_mode = asr_sync_e'(sync_q[`ASR_SYNC_MODE_HI:0]);
    assign active    = !power_q[`ASR_PWR_STBY_BIT];
    assign trig_rise = SYNC_TRIG && !trig_q;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= SYNC_TRIG;
        end
    end

    // The first trigger in direct mode synchronises; later ones mark new samples.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            synced_q <= 1'b0;
        end else if (sync_mode != ASR_SYNC_EXT_DIRECT || !active) begin
            synced_q <= 1'b0;
        end else if (trig_rise) begin
            synced_q <= 1'b1;
        end
    end

    // Delay doubles per rate step from the minimum and saturates at the maximum.
    assign dly_shift = `ASR_INTERP_MIN << RATE_FILTER_SETTING;
    assign dly_load  = (RATE_FILTER_SETTING >= `ASR_RATE_TOP || dly_shift > MAX_DLY)
                       ? MAX_DLY : dly_shift;
    assign dly_start = trig_rise && active && sync_mode == ASR_SYNC_EXT_INTERP;
    assign dly_abort = !active || sync_mode != ASR_SYNC_EXT_INTERP;

    // The converter's filter lag makes each interpolated sample a group delay old.
    asr_dly_counter u_dly (
        .clk   (REF_CLK),
        .rst_n (RESET_N),
        .start (dly_start),
        .abort (dly_abort),
        .load  (dly_load),
        .busy  (dly_busy),
        .done  (dly_done)
    );

    // Picks the sample event for the selected synchronisation mode.
    always_comb begin
        case (sync_mode)
            ASR_SYNC_INTERNAL:   rdy_src = SAMPLE_TICK;
            ASR_SYNC_EXT_DIRECT: rdy_src = trig_rise && synced_q;
            ASR_SYNC_EXT_INTERP: rdy_src = dly_done;
            ASR_SYNC_RESERVED:   rdy_src = 1'b0;
            default:             rdy_src = 1'b0;
        endcase
    end

    // Sample ready pin, silenced in standby and by the output mask.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= rdy_src && active && !power_q[`ASR_PWR_MASK_BIT];
        end
    end

    // Temperature processing runs only when enabled and out of standby.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            temp_en_q <= 1'b0;
        end else begin
            temp_en_q <= !power_q[`ASR_PWR_TOFF_BIT] && active;
        end
    end

    // Sticky event flags, cleared by writing one; a new event wins over the clear.
    assign irq_set = {6'h00, dly_start && dly_busy, rdy_src && active};
    assign irq_clr = (wr_fire && w_s0_q && wr_ok && aw_addr_q[7:2] == `ASR_IDX_IRQ_STAT)
                     ? w_lo_q : 8'h00;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_stat_q <= 8'h00;
        end else begin
            irq_stat_q <= ((irq_stat_q & ~irq_clr) | irq_set) & `ASR_WMASK_IRQ;
        end
    end

    // Interrupt level and the two pins at the programmed polarity.
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_q   <= 1'b0;
            irq_a_q <= 1'b1;
            irq_b_q <= 1'b1;
        end else begin
            irq_q   <= |(irq_stat_q & irq_mask_q);
            irq_a_q <= irq_q ^ !range_q[`ASR_RNG_POL_BIT];
            irq_b_q <= irq_q ^ !range_q[`ASR_RNG_POL_BIT];
        end
    end

    // Outputs, each taken straight from a register.
    assign AWREADY              = aw_rdy_q;
    assign WREADY               = w_rdy_q;
    assign BVALID               = bvalid_q;
    assign BRESP                = bresp_q;
    assign ARREADY              = ar_rdy_q;
    assign RVALID               = rvalid_q;
    assign RDATA                = rdata_q;
    assign RRESP                = rresp_q;
    assign SAMPLE_READY_PIN     = ready_q;
    assign OUTSIDE_CLOCK_SELECT = sync_q[`ASR_SYNC_CLK_BIT];
    assign BUS_HIGH_SPEED_SEL   = range_q[`ASR_RNG_HS_BIT];
    assign RANGE_SEL            = range_q[`ASR_RNG_FS_HI:0];
    assign TEMP_PROC_EN         = temp_en_q;
    assign STANDBY              = power_q[`ASR_PWR_STBY_BIT];
    assign SELFCHECK_MODE_EN    = self_q[`ASR_ST_MODE_BIT];
    assign SELFCHECK_FORCE_EN   = self_q[`ASR_ST_FORCE_BIT];
    assign IRQ                  = irq_q;
    assign IRQ_OUT_A            = irq_a_q;
    assign IRQ_OUT_B            = irq_b_q;

    // Checks on the behaviour above.
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    logic wr_sync, wr_range, wr_power, wr_self;
    assign wr_sync  = wr_fire && w_s0_q && wr_ok && aw_addr_q[7:2] == `ASR_IDX_SYNC;
    assign wr_range = wr_fire && w_s0_q && wr_ok && aw_addr_q[7:2] == `ASR_IDX_RANGE;
    assign wr_power = wr_fire && w_s0_q && wr_ok && aw_addr_q[7:2] == `ASR_IDX_POWER;
    assign wr_self  = wr_fire && w_s0_q && wr_ok && aw_addr_q[7:2] == `ASR_IDX_SELF;

    chk_internal_ready: assert property (
        sync_mode == ASR_SYNC_INTERNAL && SAMPLE_TICK && active && !power_q[2] |=> ready_q)
        else $error("internal sample tick did not raise ready");
    chk_direct_ready: assert property (
        sync_mode == ASR_SYNC_EXT_DIRECT && synced_q && trig_rise && active && !power_q[2]
        |=> ready_q)
        else $error("synchronised trigger did not raise ready");
    chk_interp_floor: assert property (
        dly_start && !dly_busy |-> ##1 !ready_q [*7])
        else $error("interpolated ready came sooner than eight cycles");
    chk_interp_exact: assert property (
        dly_start && !dly_busy && RATE_FILTER_SETTING == 4'h0
        ##1 (sync_mode == ASR_SYNC_EXT_INTERP && active && !power_q[2]) [*7] |-> ##1 ready_q)
        else $error("interpolated ready missing eight cycles after trigger");
    chk_clock_select: assert property (
        wr_sync |=> OUTSIDE_CLOCK_SELECT == $past(w_lo_q[2]))
        else $error("outside clock select not updated");
    chk_speed_range: assert property (
        wr_range |=> BUS_HIGH_SPEED_SEL == $past(w_lo_q[7]) && RANGE_SEL == $past(w_lo_q[1:0]))
        else $error("speed or range field not updated");
    chk_irq_polarity: assert property (
        ##1 IRQ_OUT_A == ($past(irq_q) ^ !$past(range_q[6])) && IRQ_OUT_B == IRQ_OUT_A)
        else $error("interrupt pins at wrong polarity");
    chk_ready_mask: assert property (
        power_q[2] |=> !ready_q)
        else $error("ready output not held low while masked");
    chk_temp_off: assert property (
        wr_power && (w_lo_q[1] || w_lo_q[0]) |-> ##2 !TEMP_PROC_EN)
        else $error("temperature processing left on");
    chk_rsvd_zero: assert property (
        rvalid_q |-> rdata_q[31:8] == 24'h00_0000 && !(sync_q[7:3] != 5'h00) && range_q[5:2] == 4'h0)
        else $error("reserved bits not zero");
    chk_selfcheck: assert property (
        wr_self |=> SELFCHECK_MODE_EN == $past(w_lo_q[0]) && SELFCHECK_FORCE_EN == $past(w_lo_q[1])
        && self_q[7:2] == 6'h00)
        else $error("self-check bits not updated");

    cov_interp_ready: cover property (dly_done ##1 ready_q);
    cov_direct_ready: cover property (sync_mode == ASR_SYNC_EXT_DIRECT && ready_q);
    cov_irq_clear:    cover property (irq_stat_q[0] ##1 irq_clr[0]);
    cov_overrun:      cover property (irq_set[1]);

endmodule : asr_regs
`default_nettype wire

// >>> sim/asr_trig_model.sv
// Stand-in for the sensing core and the outside trigger source.
`timescale 1ns/1ps
`default_nettype none
module asr_trig_model (
    input  wire logic clk,
    output logic      tick,
    output logic      trig
);
    // Both strobes stay low until a scenario asks for one.
    initial begin
        tick = 1'b0;
        trig = 1'b0;
    end

    // Each strobe lasts one cycle, so a trigger gives exactly one rising edge.
    always @(posedge clk) begin
        if (tick) tick <= 1'b0;
        if (trig) trig <= 1'b0;
    end

    // Raises the conversion strobe or the trigger just after the next edge.
    task fire(input logic which);
        @(posedge clk);
        trig <= which;
        tick <= !which;
    endtask : fire
endmodule : asr_trig_model
`default_nettype wire

// >>> sim/test_accel_sync_range_power_regs.sv
// Self-checking bench for the sensor control register block.
`timescale 1ns/1ps
`default_nettype none
module test_accel_sync_range_power_regs;
    logic        REF_CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [31:0] WDATA = 32'h0;
    logic [3:0]  WSTRB = 4'h0, RATE_FILTER_SETTING = 4'h0;
    wire logic   AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_TICK, SYNC_TRIG;
    wire logic   SAMPLE_READY_PIN, OUTSIDE_CLOCK_SELECT, BUS_HIGH_SPEED_SEL, TEMP_PROC_EN;
    wire logic   STANDBY, SELFCHECK_MODE_EN, SELFCHECK_FORCE_EN, IRQ, IRQ_OUT_A, IRQ_OUT_B;
    wire logic [1:0]  BRESP, RRESP, RANGE_SEL;
    wire logic [31:0] RDATA;
    logic [1:0]  resp;
    logic [31:0] rdat;
    int          n;
    int          fail_count = 0;
    int          compares = 0;
    logic [3:0]  stb = 4'hf;
    logic [7:0]  adr [4] = '{8'hac, 8'hb0, 8'hb4, 8'hb8};
    logic [7:0]  rst [4] = '{8'h00, 8'h81, 8'h01, 8'h00};
    logic [7:0]  msk [4] = '{8'h07, 8'hc3, 8'h07, 8'h03};
    logic [3:0]  rt [3] = '{4'h0, 4'h2, 4'h5};
    int          dly [3] = '{8, 32, 64};

    // The clock runs at 40 MHz.
    always #12.5 REF_CLK = ~REF_CLK;

    // Interpolation cap cut to 64 cycles so the long delays stay short.
    asr_regs #(.INTERP_MAX_CYC(64)) u_dut (
        .REF_CLK(REF_CLK), .RESET_N(RESET_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .SAMPLE_TICK(SAMPLE_TICK), .SYNC_TRIG(SYNC_TRIG),
        .RATE_FILTER_SETTING(RATE_FILTER_SETTING), .SAMPLE_READY_PIN(SAMPLE_READY_PIN),
        .OUTSIDE_CLOCK_SELECT(OUTSIDE_CLOCK_SELECT), .BUS_HIGH_SPEED_SEL(BUS_HIGH_SPEED_SEL),
        .RANGE_SEL(RANGE_SEL), .TEMP_PROC_EN(TEMP_PROC_EN), .STANDBY(STANDBY),
        .SELFCHECK_MODE_EN(SELFCHECK_MODE_EN), .SELFCHECK_FORCE_EN(SELFCHECK_FORCE_EN),
        .IRQ(IRQ), .IRQ_OUT_A(IRQ_OUT_A), .IRQ_OUT_B(IRQ_OUT_B)
    );

    asr_trig_model u_trig (.clk(REF_CLK), .tick(SAMPLE_TICK), .trig(SYNC_TRIG));

    // Compares one value and reports a mismatch at once.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task conclude;
        $display("compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // One write; address and data are offered together and released when taken.
    task wr(input logic [7:0] a, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge REF_CLK);
        AWADDR <= a;
        AWVALID <= 1'b1;
        WDATA <= {4{d}}; // Upper bytes carry copies that the block must ignore.
        WSTRB <= stb;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            t++;
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1 && t < 100);
        if (t >= 100) fail_count++;
        resp = BRESP;
        BREADY <= 1'b0;
    endtask : wr

    // One read; the address stands until taken, rready until the answer.
    task rd(input logic [7:0] a);
        int t;
        t = 0;
        @(posedge REF_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            t++;
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1 && t < 100);
        if (t >= 100) fail_count++;
        rdat = RDATA;
        resp = RRESP;
        RREADY <= 1'b0;
    endtask : rd

    // Counts edges until the ready pulse shows; zero when none comes in 100 cycles.
    task wait_ready;
        n = 0;
        for (int i = 1; i <= 100 && n == 0; i++) begin
            @(posedge REF_CLK);
            #1;
            if (SAMPLE_READY_PIN === 1'b1) n = i;
        end
    endtask : wait_ready

    // Lets registered outputs catch up with a write.
    task settle;
        repeat (2) @(posedge REF_CLK);
        #1;
    endtask : settle

    // Changes the sync mode inside standby, then applies the power value.
    task mode(input logic [7:0] s, input logic [7:0] p);
        wr(8'hb4, 8'h01);
        wr(8'hac, s);
        wr(8'hb4, p);
    endtask : mode

    // Main sequence of scenarios.
    initial begin
        repeat (2) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        #1;
        chk(BUS_HIGH_SPEED_SEL, 1);
        chk(RANGE_SEL, 1);
        chk(STANDBY, 1);
        chk(TEMP_PROC_EN, 0);
        chk(IRQ_OUT_A, 1);
        chk(OUTSIDE_CLOCK_SELECT, 0);
        for (int i = 0; i < 4; i++) begin
            rd(adr[i]);
            chk(rdat, rst[i]);
            wr(adr[i], 8'hff);
            rd(adr[i]);
            chk(rdat, msk[i]);
        end
        chk(OUTSIDE_CLOCK_SELECT, 1);
        chk(SELFCHECK_MODE_EN, 1);
        chk(SELFCHECK_FORCE_EN, 1);
        wr(8'hbc, 8'hff);
        chk(resp, 2'b10);
        rd(8'hbc);
        chk(resp, 2'b10);
        wr(8'had, 8'h00);
        chk(resp, 2'b10);
        chk(OUTSIDE_CLOCK_SELECT, 1);
        wr(8'hb8, 8'h00);
        chk(SELFCHECK_MODE_EN, 0);
        // A write without the low byte strobe is answered but changes nothing.
        stb = 4'he;
        wr(8'hb8, 8'h03);
        stb = 4'hf;
        chk(resp, 2'b00);
        chk(SELFCHECK_MODE_EN, 0);
        chk(SELFCHECK_FORCE_EN, 0);
        for (int k = 1; k < 4; k++) begin
            wr(8'hb0, 8'(k));
            chk(RANGE_SEL, k);
            chk(BUS_HIGH_SPEED_SEL, 0);
        end
        wr(8'hb4, 8'h00);
        settle();
        chk(TEMP_PROC_EN, 1);
        wr(8'hb4, 8'h02);
        settle();
        chk(TEMP_PROC_EN, 0);
        wr(8'hb4, 8'h01);
        settle();
        chk(TEMP_PROC_EN, 0);
        mode(8'h00, 8'h00);
        u_trig.fire(1'b0);
        wait_ready();
        chk(n, 1);
        wr(8'hb4, 8'h04);
        u_trig.fire(1'b0);
        wait_ready();
        chk(n, 0);
        wr(8'hc4, 8'h01);
        settle();
        chk(IRQ, 1);
        chk(IRQ_OUT_A, 0);
        wr(8'hb4, 8'h01);
        wr(8'hb0, 8'h43);
        wr(8'hb4, 8'h04);
        settle();
        chk(IRQ_OUT_B, 1);
        wr(8'hc0, 8'h03);
        settle();
        chk(IRQ_OUT_A, 0);
        wr(8'hc4, 8'h00);
        u_trig.fire(1'b0);
        wait_ready();
        settle();
        chk(IRQ, 0);
        rd(8'hc0);
        chk(rdat, 1);
        mode(8'h01, 8'h00);
        u_trig.fire(1'b1);
        wait_ready();
        chk(n, 0);
        u_trig.fire(1'b1);
        wait_ready();
        chk(n, 1);
        mode(8'h02, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge REF_CLK);
            RATE_FILTER_SETTING <= rt[i];
            u_trig.fire(1'b1);
            wait_ready();
            chk(n, dly[i]);
        end
        mode(8'h03, 8'h00);
        u_trig.fire(1'b1);
        wait_ready();
        chk(n, 0);
        // A reset in mid-run returns the settings to their reset values.
        @(posedge REF_CLK);
        RESET_N <= 1'b0;
        @(posedge REF_CLK);
        RESET_N <= 1'b1;
        #1;
        chk(BUS_HIGH_SPEED_SEL, 1);
        chk(RANGE_SEL, 1);
        chk(STANDBY, 1);
        rd(8'hb4);
        chk(rdat, 8'h01);
        conclude();
    end

    // Cuts a hang short well after the scenarios should have ended.
    initial begin
        repeat (20000) @(posedge REF_CLK);
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
